// ---- hdl/oad_pkg.sv ----
// constants and types for the operand address decoder
package oad_pkg;
	localparam int ADDR_W = 24;
	localparam logic [7:0] SFR_BASE = 8'h80;
	localparam logic [7:0] BIT_RAM_BASE = 8'h20;
	localparam logic [7:0] BIT_SFR_HALF = 8'h80;
	localparam logic [23:0] EXT_BIT_LO = 24'h000020;
	localparam logic [23:0] EXT_BIT_HI = 24'h00007f;
	localparam logic [15:0] FILL_ZERO = 16'h0000;
	localparam logic [15:0] FILL_ONE = 16'hffff;
	localparam logic [5:0] DW_HI_A = 6'h38;
	localparam logic [5:0] DW_HI_B = 6'h3c;
	localparam logic [5:0] DW_LO_MAX = 6'h1c;
	localparam int STATE_CLKS = 2;
	// operand kinds presented by the decode stage
	typedef enum logic [3:0] {
		OAD_DIRECT_BYTE_ADDRESS = 4'h0, OAD_DIRECT_WIDE_ADDRESS = 4'h1, OAD_IMM8 = 4'h2, OAD_IMM16 = 4'h3,
		OAD_IMM_Z = 4'h4, OAD_IMM_O = 4'h5, OAD_SHORT = 4'h6, OAD_BIT_LEG = 4'h7,
		OAD_BIT_EXT = 4'h8, OAD_REL = 4'h9, OAD_BLOCK = 4'ha, OAD_REGION = 4'hb,
		OAD_FULL = 4'hc, OAD_PTR_IND = 4'hd, OAD_WORD_IND = 4'he, OAD_DWORD_IND = 4'hf
	} oad_kind_t;
	typedef enum logic [1:0] {
		OAD_W_BYTE = 2'h0, OAD_W_WORD = 2'h1, OAD_W_DWORD = 2'h2
	} oad_width_t;
	typedef enum logic [1:0] {
		OAD_SP_ONCHIP = 2'h0, OAD_SP_SFR = 2'h1, OAD_SP_MEM = 2'h2
	} oad_space_t;
	typedef enum logic [1:0] {
		OAD_ST_IDLE = 2'b01, OAD_ST_BUSY = 2'b10
	} oad_state_t;
endpackage : oad_pkg

// ---- hdl/oad_decode.sv ----
// operand decode and effective address generation
// Contract
// - low direct byte onchip, high half SFR
// - direct width follows other operand width; wide direct always reports byte
// - wide direct address upper byte zero
// - short immediate 8 bits, wide 16
// - 32-bit immediate upper word zeros or ones
// - short immediate only one, two, four
// - low legacy bits map bytes 20h-2Fh
// - high legacy bits map SFRs ending 0h/8h
// - extended bits reach low RAM or SFR
// - relative offset signed, added to next PC
// - block target keeps 2KB block
// - region target keeps 64KB region
// - full target replaces whole PC
// - pointer indirect uses byte reg 0/1
// - bank byte register index 0 to 7
// - file byte register index 0 to 15
// - word register index even 0 to 30
// - word indirect stays in lowest 64KB
// - displaced word indirect adds signed offset
// - dword index multiples of four 0 to 28, 56, 60
// - dword indirect spans 24 bits, displacement optional
// - each state lasts two clock cycles
`timescale 1ns/1ps
module oad_decode
	import oad_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic op_valid,
	input wire oad_pkg::oad_kind_t op_kind,
	input wire logic [15:0] op_field,
	input wire logic [ADDR_W-1:0] op_wide,
	input wire oad_pkg::oad_width_t other_width,
	input wire logic other_width_valid,
	input wire logic [ADDR_W-1:0] next_pc,
	input wire logic [7:0] ptr_reg_value,
	input wire logic [15:0] word_reg_value,
	input wire logic [31:0] dword_reg_value,
	input wire logic disp_enable,
	input wire logic [1:0] reg_form,
	input wire logic [5:0] reg_index_in,
	input wire logic sfr_defined,
	output logic done,
	output logic [ADDR_W-1:0] eff_addr,
	output logic [31:0] operand,
	output oad_pkg::oad_space_t space,
	output oad_pkg::oad_width_t access_width,
	output logic [2:0] bit_pos,
	output logic [5:0] reg_index,
	output logic ptr_select,
	output logic reg_error,
	output logic op_error,
	output logic state_tick
);
	import oad_pkg::*;

	// reset enters asynchronously but is released on a clock edge, so no flop
	// sees the release half way through a cycle
	logic rst_meta, rst_sync;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// state tick divider: one state is STATE_CLKS clocks
	localparam int TICK_W = $clog2(STATE_CLKS);
	logic [TICK_W-1:0] tick_cnt, next_tick_cnt;
	logic next_state_tick;
	always_comb begin
		next_tick_cnt = tick_cnt + 1'b1;
		next_state_tick = 1'b0;
		if (tick_cnt == TICK_W'(STATE_CLKS - 1)) begin
			next_tick_cnt = '0;
			next_state_tick = 1'b1;
		end
	end

	// idle takes a request, busy waits for the end of the current state
	oad_state_t st, next_st;

	logic [ADDR_W-1:0] a;
	logic [31:0] v;
	oad_space_t sp;
	oad_width_t w;
	logic [2:0] bp;
	logic [5:0] ri;
	logic rerr, oerr, psel;
	logic [15:0] disp;
	logic [15:0] wsum;
	logic [23:0] dsum;

	always_comb begin
		a = '0;
		v = '0;
		sp = OAD_SP_MEM;
		w = OAD_W_BYTE;
		bp = 3'h0;
		oerr = 1'b0;
		psel = 1'b0;
		disp = disp_enable ? op_field : 16'h0000;
		wsum = word_reg_value + disp;
		dsum = dword_reg_value[23:0] + {{8{disp[15]}}, disp};
		unique case (op_kind)
			OAD_DIRECT_BYTE_ADDRESS: begin
				a = {16'h0000, op_field[7:0]};
				sp = (op_field[7:0] < SFR_BASE) ? OAD_SP_ONCHIP : OAD_SP_SFR;
				w = other_width_valid ? other_width : OAD_W_BYTE;
			end
			OAD_DIRECT_WIDE_ADDRESS: begin
				a = {8'h00, op_field};
				sp = OAD_SP_MEM;
			end
			// immediates report their own width so the operand path can size itself
			OAD_IMM8: begin
				v = {24'h000000, op_field[7:0]};
				w = OAD_W_BYTE;
			end
			OAD_IMM16: begin
				v = {16'h0000, op_field};
				w = OAD_W_WORD;
			end
			OAD_IMM_Z: begin
				v = {FILL_ZERO, op_field};
				w = OAD_W_DWORD;
			end
			OAD_IMM_O: begin
				v = {FILL_ONE, op_field};
				w = OAD_W_DWORD;
			end
			OAD_SHORT: begin
				// two-bit code: 0->1, 1->2, 2->4, 3 is illegal
				unique case (op_field[1:0])
					2'h0: v = 32'h00000001;
					2'h1: v = 32'h00000002;
					2'h2: v = 32'h00000004;
					default: begin
						v = 32'h00000001;
						oerr = 1'b1;
					end
				endcase
			end
			OAD_BIT_LEG: begin
				bp = op_field[2:0];
				if (op_field[7:0] < BIT_SFR_HALF) begin
					a = {16'h0000, BIT_RAM_BASE + {4'h0, op_field[6:3]}};
					sp = OAD_SP_ONCHIP;
				end else begin
					a = {16'h0000, op_field[7:3], 3'b000};
					sp = OAD_SP_SFR;
				end
			end
			OAD_BIT_EXT: begin
				// byte address in op_wide, bit number in op_field[2:0]
				bp = op_field[2:0];
				a = op_wide;
				if (op_wide >= EXT_BIT_LO && op_wide <= EXT_BIT_HI) begin
					sp = OAD_SP_ONCHIP;
				end else if (op_wide[23:8] == 16'h0000 && op_wide[7:0] >= SFR_BASE
					&& sfr_defined) begin
					sp = OAD_SP_SFR;
				end else begin
					oerr = 1'b1;
				end
			end
			// jump targets: the sum wraps in 24 bits, no carry out is kept
			OAD_REL: begin
				a = next_pc + {{16{op_field[7]}}, op_field[7:0]};
				sp = OAD_SP_MEM;
			end
			OAD_BLOCK: begin
				a = {next_pc[23:11], op_field[10:0]};
				sp = OAD_SP_MEM;
			end
			OAD_REGION: begin
				a = {next_pc[23:16], op_field};
				sp = OAD_SP_MEM;
			end
			OAD_FULL: begin
				a = op_wide;
				sp = OAD_SP_MEM;
			end
			OAD_PTR_IND: begin
				psel = op_field[0];
				a = {16'h0000, ptr_reg_value};
				sp = OAD_SP_ONCHIP;
			end
			// word pointer stays in page 00 even when the displacement carries out
			OAD_WORD_IND: begin
				a = {8'h00, wsum};
				sp = OAD_SP_MEM;
			end
			OAD_DWORD_IND: begin
				a = dsum;
				sp = OAD_SP_MEM;
			end
			default: oerr = 1'b1;
		endcase
	end

	// register index check; reg_form 0 bank byte, 1 file byte, 2 word, 3 dword
	always_comb begin
		ri = reg_index_in;
		rerr = 1'b0;
		unique case (reg_form)
			2'h0: begin
				ri = {3'b000, reg_index_in[2:0]};
				rerr = reg_index_in[5:3] != 3'b000;
			end
			2'h1: begin
				ri = {2'b00, reg_index_in[3:0]};
				rerr = reg_index_in[5:4] != 2'b00;
			end
			2'h2: rerr = reg_index_in[0] || reg_index_in[5];
			2'h3: rerr = reg_index_in[1:0] != 2'b00 || (reg_index_in > DW_LO_MAX
				&& reg_index_in != DW_HI_A && reg_index_in != DW_HI_B);
			default: rerr = 1'b1;
		endcase
		if (rerr) begin
			ri = '0;
		end
	end

	// one request per state; result held until the next request
	logic next_done;
	always_comb begin
		next_st = st;
		next_done = 1'b0;
		unique case (st)
			OAD_ST_IDLE: begin
				if (op_valid) begin
					next_st = OAD_ST_BUSY;
				end
			end
			OAD_ST_BUSY: begin
				if (state_tick) begin
					next_st = OAD_ST_IDLE;
					next_done = 1'b1;
				end
			end
			default: next_st = OAD_ST_IDLE;
		endcase
	end

	// a request is only taken while idle; one arriving while busy is lost
	logic cap;
	assign cap = (st == OAD_ST_IDLE) && op_valid;

	// results hold until the next taken request, so the consumer may sample late
	logic [ADDR_W-1:0] next_eff_addr;
	logic [31:0] next_operand;
	oad_space_t next_space;
	oad_width_t next_access_width;
	logic [2:0] next_bit_pos;
	logic [5:0] next_reg_index;
	logic next_ptr_select;
	logic next_reg_error;
	logic next_op_error;
	always_comb begin
		next_eff_addr = eff_addr;
		next_operand = operand;
		next_space = space;
		next_access_width = access_width;
		next_bit_pos = bit_pos;
		next_reg_index = reg_index;
		next_ptr_select = ptr_select;
		next_reg_error = reg_error;
		next_op_error = op_error;
		if (cap) begin
			next_eff_addr = a;
			next_operand = v;
			next_space = sp;
			next_access_width = w;
			next_bit_pos = bp;
			next_reg_index = ri;
			next_ptr_select = psel;
			next_reg_error = rerr;
			next_op_error = oerr;
		end
	end

	// divider runs free from reset release so states keep a fixed phase
	always_ff @(posedge ref_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			tick_cnt <= '0;
			state_tick <= 1'b0;
		end else begin
			tick_cnt <= next_tick_cnt;
			state_tick <= next_state_tick;
		end
	end

	// request handshake
	always_ff @(posedge ref_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			st <= OAD_ST_IDLE;
			done <= 1'b0;
		end else begin
			st <= next_st;
			done <= next_done;
		end
	end

	// result registers
	always_ff @(posedge ref_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			eff_addr <= '0;
			operand <= '0;
			space <= OAD_SP_MEM;
			access_width <= OAD_W_BYTE;
			bit_pos <= 3'h0;
			reg_index <= 6'h00;
			ptr_select <= 1'b0;
			reg_error <= 1'b0;
			op_error <= 1'b0;
		end else begin
			eff_addr <= next_eff_addr;
			operand <= next_operand;
			space <= next_space;
			access_width <= next_access_width;
			bit_pos <= next_bit_pos;
			reg_index <= next_reg_index;
			ptr_select <= next_ptr_select;
			reg_error <= next_reg_error;
			op_error <= next_op_error;
		end
	end
endmodule : oad_decode

// ---- tb/oad_decode_assertions.sv ----
// concurrent checks on the operand address decoder ports
`timescale 1ns/1ps
module oad_chk
	import oad_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic op_valid,
	input wire oad_pkg::oad_kind_t op_kind,
	input wire logic [15:0] op_field,
	input wire logic [ADDR_W-1:0] next_pc,
	input wire logic done,
	input wire logic [ADDR_W-1:0] eff_addr,
	input wire logic [31:0] operand,
	input wire oad_pkg::oad_space_t space,
	input wire logic [5:0] reg_index,
	input wire logic reg_error,
	input wire logic state_tick
);
	logic busy;
	logic next_busy;
	logic take;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// a request is taken when idle or in the done cycle
	assign take = op_valid && (!busy || done);
	always_comb begin
		next_busy = take | (busy & ~done);
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
		end else begin
			busy <= next_busy;
		end
	end
	property p_tick;
		state_tick |=> !state_tick ##1 state_tick;
	endproperty
	a_tick: assert property (p_tick) else $error("state tick not every 2 clocks");
	property p_done;
		take |-> ##[1:4] done ##1 !done;
	endproperty
	a_done: assert property (p_done) else $error("done missing or long");
	property p_direct_byte_address;
		take && op_kind == oad_kind_t'(4'h0) |=> eff_addr == {16'h0000, $past(op_field[7:0])}
			&& space == ($past(op_field[7]) ? OAD_SP_SFR : OAD_SP_ONCHIP);
	endproperty
	a_direct_byte_address: assert property (p_direct_byte_address) else $error("direct byte decode wrong");
	property p_direct_wide_address;
		take && op_kind == oad_kind_t'(4'h1) |=> eff_addr == {8'h00, $past(op_field)};
	endproperty
	a_direct_wide_address: assert property (p_direct_wide_address) else $error("wide direct not in page 0");
	property p_rel;
		take && op_kind == oad_kind_t'(4'h9) |=> eff_addr ==
			$past(next_pc) + {{16{$past(op_field[7])}}, $past(op_field[7:0])};
	endproperty
	a_rel: assert property (p_rel) else $error("relative target wrong");
	property p_block;
		take && op_kind == oad_kind_t'(4'ha) |=>
			eff_addr == {$past(next_pc[23:11]), $past(op_field[10:0])};
	endproperty
	a_block: assert property (p_block) else $error("block target wrong");
	property p_short;
		take && op_kind == oad_kind_t'(4'h6) && op_field[1:0] != 2'h3 |=>
			operand == (32'h1 << $past(op_field[1:0]));
	endproperty
	a_short: assert property (p_short) else $error("short constant wrong");
	property p_rerr;
		reg_error |-> reg_index == 6'h00;
	endproperty
	a_rerr: assert property (p_rerr) else $error("reserved index produced");
endmodule : oad_chk

bind oad_decode oad_chk i_oad_chk (.*);

// ---- tb/tb.sv ----
// self-checking bench for the operand address decoder
`timescale 1ns/1ps
module tb;
	import oad_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic op_valid = 1'b0;
	oad_kind_t op_kind = oad_kind_t'(4'h0);
	logic [15:0] op_field = 16'h0000;
	logic [23:0] op_wide = 24'h000000;
	logic [23:0] next_pc = 24'h12f7fe;
	oad_width_t other_width = OAD_W_WORD;
	logic other_width_valid = 1'b0;
	logic [7:0] ptr_reg_value = 8'hfe;
	logic [15:0] word_reg_value = 16'hfff0;
	logic [31:0] dword_reg_value = 32'h00123456;
	logic disp_enable = 1'b0;
	logic [1:0] reg_form = 2'h0;
	logic [5:0] reg_index_in = 6'h00;
	logic sfr_defined = 1'b0;
	logic done, ptr_select, reg_error, op_error, state_tick;
	logic [23:0] eff_addr;
	logic [31:0] operand;
	oad_space_t space;
	oad_width_t access_width;
	logic [2:0] bit_pos;
	logic [5:0] reg_index;
	int n_fail = 0;
	int tests_run = 0;
	always #25 ref_clk = ~ref_clk;
	oad_decode i_oad_decode (.*);
	task chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	// one request, then wait for its done pulse under a bound
	task run(input logic [3:0] k, input logic [15:0] f);
		int i;
		@(posedge ref_clk);
		#2 op_valid = 1'b1;
		op_kind = oad_kind_t'(k);
		op_field = f;
		@(posedge ref_clk);
		#2 op_valid = 1'b0;
		i = 0;
		while (done !== 1'b1 && i < 8) begin
			@(posedge ref_clk);
			#2 i++;
		end
		chk(done, 1'b1);
	endtask : run
	task s_direct;
		run(4'h0, 16'h007f); chk({space, eff_addr}, {OAD_SP_ONCHIP, 24'h00007f});
		run(4'h0, 16'h0080); chk({space, eff_addr}, {OAD_SP_SFR, 24'h000080});
		other_width_valid = 1'b1;
		run(4'h0, 16'h0030); chk(access_width, OAD_W_WORD);
		other_width_valid = 1'b0;
		run(4'h0, 16'h0030); chk(access_width, OAD_W_BYTE);
		run(4'h1, 16'hffff); chk(eff_addr, 24'h00ffff);
	endtask : s_direct
	task s_imm;
		run(4'h2, 16'h12a5); chk(operand, 32'h000000a5);
		run(4'h3, 16'h8001); chk(operand, 32'h00008001);
		run(4'h4, 16'h8001); chk(operand, 32'h00008001);
		run(4'h5, 16'h8001); chk(operand, 32'hffff8001);
		for (int i = 0; i < 3; i++) begin
			run(4'h6, 16'(i)); chk(operand, 32'h1 << i);
		end
	endtask : s_imm
	task s_bits_jumps;
		run(4'h7, 16'h000a); chk({space, bit_pos, eff_addr}, {OAD_SP_ONCHIP, 27'h2000021});
		run(4'h7, 16'h008b); chk({space, bit_pos, eff_addr}, {OAD_SP_SFR, 27'h3000088});
		op_wide = 24'h00007f;
		run(4'h8, 16'h0000); chk({op_error, eff_addr}, 25'h000007f);
		run(4'h9, 16'h0080); chk(eff_addr, 24'h12f77e);
		run(4'ha, 16'h0001); chk(eff_addr, 24'h12f001);
		run(4'hb, 16'habcd); chk(eff_addr, 24'h12abcd);
		op_wide = 24'ha5a5a5;
		run(4'hc, 16'h0000); chk(eff_addr, 24'ha5a5a5);
	endtask : s_bits_jumps
	task s_indirect;
		run(4'hd, 16'h0001); chk({ptr_select, eff_addr}, 25'h10000fe);
		run(4'he, 16'h0000); chk(eff_addr, 24'h00fff0);
		disp_enable = 1'b1;
		run(4'he, 16'h0020); chk(eff_addr, 24'h000010);
		run(4'hf, 16'hfff0); chk(eff_addr, 24'h123446);
		disp_enable = 1'b0;
	endtask : s_indirect
	task rg(input logic [1:0] fm, input logic [5:0] ix, input logic [6:0] e);
		reg_form = fm;
		reg_index_in = ix;
		run(4'he, 16'h0000);
		chk({reg_error, reg_index}, e);
	endtask : rg
	task s_regs;
		rg(2'h0, 6'h07, 7'h07);
		rg(2'h0, 6'h08, 7'h40);
		rg(2'h1, 6'h0f, 7'h0f);
		rg(2'h2, 6'h1e, 7'h1e);
		rg(2'h2, 6'h05, 7'h40);
		rg(2'h3, 6'h38, 7'h38);
		rg(2'h3, 6'h20, 7'h40);
	endtask : s_regs
	task s_errors;
		run(4'h6, 16'h0003);
		chk(op_error, 1'b1);
		chk(operand, 32'h00000001);
		run(4'h4, 16'h0001);
		chk(access_width, OAD_W_DWORD);
		sfr_defined = 1'b1;
		op_wide = 24'h0000a8;
		run(4'h8, 16'h0005);
		chk({op_error, space, bit_pos}, {1'b0, OAD_SP_SFR, 3'h5});
		op_wide = 24'h000010;
		run(4'h8, 16'h0000);
		chk({op_error, space}, {1'b1, OAD_SP_MEM});
		sfr_defined = 1'b0;
	endtask : s_errors
	task close_out;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : close_out
	initial begin
		repeat (4) @(posedge ref_clk);
		#2 rst_n = 1'b1;
		repeat (3) @(posedge ref_clk);
		s_direct();
		s_imm();
		s_bits_jumps();
		s_indirect();
		s_regs();
		s_errors();
		close_out();
	end
	// the whole run needs well under 20 us
	initial begin
		#100000;
		n_fail++;
		close_out();
	end
endmodule : tb
